/* cods_checker.sv */
// Purpose: port checker for the scaling data path
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to cods_top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module cods_checker #(
  parameter [23:0] WDOG_CYCLES = 24'd50
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pd_vld,
  input wire logic [15:0] pd_data,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_r,
  input wire logic [11:0] dac_code_r,
  input wire logic dac_load_r,
  input wire logic run_led_r,
  input wire logic irq_r
);
  logic [24:0] idle_r;
  logic [3:0] feat_r;
  logic [2:0] en_r;
  wire [11:0] exp_code = pd_data[15] ? 12'h000 : pd_data[14:3];
  wire direct_ok = (feat_r[1:0] == 2'h0) && (feat_r[3:2] != 2'h1);
  // idle cycles since last word, shadow of feature low bits and irq enables
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_r <= 25'h0000000;
      feat_r <= 4'h0;
      en_r <= 3'h0;
    end else begin
      idle_r <= pd_vld ? 25'h0000000 : idle_r + {24'h000000, ~&idle_r};
      if (reg_wr && reg_addr == 8'h20) feat_r <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 8'h32) en_r <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_load_latency: assert property (pd_vld |-> ##4 dac_load_r)
    else $error("no converter load four cycles after a word");
  a_direct_code: assert property (dac_load_r && $past(pd_vld, 4) && $past(direct_ok, 4)
    |-> dac_code_r == $past(exp_code, 4)) else $error("unscaled word gave a wrong code");
  a_code_hold: assert property (!dac_load_r |-> $stable(dac_code_r))
    else $error("converter code moved without a load");
  a_wdog_expire: assert property (idle_r >= WDOG_CYCLES |-> !run_led_r)
    else $error("run indicator still on after watchdog period");
  a_wdog_early: assert property ($fell(run_led_r) |-> idle_r == WDOG_CYCLES)
    else $error("run indicator dropped too early");
  a_run_resume: assert property (pd_vld |=> run_led_r)
    else $error("run indicator off after a word");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata_r == 16'h0000)
    else $error("read data outside read cycle");
  a_irq_masked: assert property (en_r == 3'h0 && $past(en_r) == 3'h0 |-> !irq_r)
    else $error("interrupt raised while all sources masked");
endmodule
bind cods_top cods_checker #(.WDOG_CYCLES(WDOG_CYCLES)) chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
  .pd_vld(pd_vld), .pd_data(pd_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .dac_code_r(dac_code_r), .dac_load_r(dac_load_r),
  .run_led_r(run_led_r), .irq_r(irq_r));
`default_nettype wire

/* cods_coupler.sv */
// Purpose: coupler model sending process words
// Assumes: go is a one-cycle request per word from the bench
// Notes: data line shows a changing pattern between words
`timescale 1ns/1ns
`default_nettype none
module cods_coupler (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [15:0] word,
  output logic pd_vld,
  output logic [15:0] pd_data
);
  // one strobe per word, bench paces words well inside the watchdog period except in the watchdog test, which lets it expire
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_vld <= 1'b0;
      pd_data <= 16'h0000;
    end else begin
      pd_vld <= go;
      pd_data <= go ? word : ~pd_data;
    end
  end
endmodule
`default_nettype wire

/* cods_line.v */
// Purpose: one straight-line stage, offset plus gain times input, registered
// Assumes: gain is unsigned with CODS_GAIN_FRAC fraction bits, offset and data signed
// Notes: result saturates to the signed 16-bit range; disabled stage passes data
`timescale 1ns/1ns
`default_nettype none
`include "cods_regs.vh"

module cods_line (
  input wire sys_clk,
  input wire rst_b,
  input wire in_vld,
  input wire [15:0] in_x,
  input wire stage_en,
  input wire [15:0] ofs,
  input wire [15:0] gain,
  output reg out_vld_r,
  output reg [15:0] out_y_r,
  output reg out_sat_r
);

  wire signed [32:0] prod;
  wire signed [33:0] sum;
  wire fits;
  wire [15:0] y_sat;

  // gain times input, scaled back, plus offset
  assign prod = $signed({1'b0, gain}) * $signed(in_x);
  assign sum = (prod >>> `CODS_GAIN_FRAC) + $signed({{18{ofs[15]}}, ofs});
  // clip to signed 16-bit range
  assign fits = (sum[33:15] == {19{1'b0}}) || (sum[33:15] == {19{1'b1}});
  assign y_sat = fits ? sum[15:0] : (sum[33] ? 16'h8000 : 16'h7FFF);

  // output register of the stage
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_vld_r <= 1'b0;
      out_y_r <= 16'h0000;
      out_sat_r <= 1'b0;
    end else begin
      out_vld_r <= in_vld;
      if (in_vld) begin
        out_y_r <= stage_en ? y_sat : in_x;
        out_sat_r <= stage_en & ~fits;
      end else begin
        out_sat_r <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* cods_regs.vh */
// Purpose: register indexes, field positions, reset values and timing for the scaling block
// Assumes: included by the design files by its bare name
// Notes: definitions only
`ifndef CODS_REGS_VH
`define CODS_REGS_VH

// ----------------------------------------------------------------
// register indexes on the plain register port
// ----------------------------------------------------------------
`define CODS_IDX_FACT_OFS 8'h13
`define CODS_IDX_FACT_GAIN 8'h14
`define CODS_IDX_FEATURE 8'h20
`define CODS_IDX_CUST_OFS 8'h21
`define CODS_IDX_CUST_GAIN 8'h22
`define CODS_IDX_SUBST 8'h23
`define CODS_IDX_IRQ_STAT 8'h30
`define CODS_IDX_IRQ_CLR 8'h31
`define CODS_IDX_IRQ_EN 8'h32
`define CODS_IDX_STATUS 8'h33
`define CODS_IDX_DAC_CODE 8'h34

// ----------------------------------------------------------------
// feature register fields
// ----------------------------------------------------------------
`define CODS_FEAT_CUST_EN 0
`define CODS_FEAT_FACT_EN 1
`define CODS_FEAT_FMT_LSB 2
`define CODS_FEAT_FMT_MSB 3
`define CODS_FMT_TWOS 2'h0
`define CODS_FMT_SGNMAG 2'h1

// ----------------------------------------------------------------
// event bits of status, clear and enable registers
// ----------------------------------------------------------------
`define CODS_EV_WDOG 0
`define CODS_EV_SAT 1
`define CODS_EV_RESUME 2
`define CODS_EV_W 3

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define CODS_ST_EXPIRED 0
`define CODS_ST_RUN 1

// ----------------------------------------------------------------
// reset values and arithmetic constants
// ----------------------------------------------------------------
`define CODS_RST_OFS 16'h0000
`define CODS_RST_GAIN 16'h0400
`define CODS_RST_FEAT 16'h0000
`define CODS_RST_SUBST 12'h000
`define CODS_RST_IRQ_EN 3'h0
`define CODS_GAIN_FRAC 10
`define CODS_DAC_MIN 12'h000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// period in ms and clock in kHz, sized to the idle counter
`define CODS_WDOG_MS 24'h000064
`define CODS_CLK_KHZ 24'h01E848
`define CODS_WDOG_CYCLES (`CODS_WDOG_MS * `CODS_CLK_KHZ)

`endif

/* cods_top.v */
// Purpose: data path of a current output channel: format, two scaling stages, watchdog
// Assumes: process data and register port run on sys_clk, coupler logic on the same clock
// Notes: four cycles from a process word to the converter load pulse
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "cods_regs.vh"

module cods_top #(
  parameter [23:0] WDOG_CYCLES = `CODS_WDOG_CYCLES
) (
  input wire sys_clk,
  input wire rst_b,
  input wire pd_vld,
  input wire [15:0] pd_data,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata_r,
  output reg [11:0] dac_code_r,
  output reg dac_load_r,
  output reg run_led_r,
  output reg irq_r
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // presentation format to signed two's complement
  function [15:0] fmt_conv;
    input [1:0] fmt;
    input [15:0] d;
    begin
      case (fmt)
        `CODS_FMT_SGNMAG: begin
          fmt_conv = d[15] ? (16'h0000 - {1'b0, d[14:0]}) : {1'b0, d[14:0]};
        end
        default: begin
          fmt_conv = d;
        end
      endcase
    end
  endfunction

  // signed value to converter code, negatives clip to range minimum
  function [11:0] to_code;
    input [15:0] y;
    begin
      to_code = y[15] ? `CODS_DAC_MIN : y[14:3];
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] fact_ofs_r;
  reg [15:0] fact_gain_r;
  reg [15:0] feature_r;
  reg [15:0] cust_ofs_r;
  reg [15:0] cust_gain_r;
  reg [11:0] subst_r;
  reg [2:0] irq_stat_r;
  reg [2:0] irq_stat_nxt;
  reg [2:0] irq_en_r;
  reg [15:0] rdata_nxt;

  // data path state
  reg fmt_vld_r;
  reg [15:0] fmt_x_r;
  reg [23:0] wdog_cnt_r;
  reg expired_r;

  wire fact_vld;
  wire [15:0] fact_y;
  wire fact_sat;
  wire cust_vld;
  wire [15:0] cust_y;
  wire cust_sat;
  wire wr_clr;
  wire wdog_hit;
  wire ev_wdog;
  wire ev_sat;
  wire ev_resume;
  wire subst_wr;
  reg [2:0] ev_vec;
  reg [15:0] status_word;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------

  // software writable registers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fact_ofs_r <= `CODS_RST_OFS;
      fact_gain_r <= `CODS_RST_GAIN;
      feature_r <= `CODS_RST_FEAT;
      cust_ofs_r <= `CODS_RST_OFS;
      cust_gain_r <= `CODS_RST_GAIN;
      subst_r <= `CODS_RST_SUBST;
      irq_en_r <= `CODS_RST_IRQ_EN;
    end else if (reg_wr) begin
      case (reg_addr)
        `CODS_IDX_FACT_OFS: begin
          fact_ofs_r <= reg_wdata;
        end
        `CODS_IDX_FACT_GAIN: begin
          fact_gain_r <= reg_wdata;
        end
        `CODS_IDX_FEATURE: begin
          feature_r <= reg_wdata;
        end
        `CODS_IDX_CUST_OFS: begin
          cust_ofs_r <= reg_wdata;
        end
        `CODS_IDX_CUST_GAIN: begin
          cust_gain_r <= reg_wdata;
        end
        `CODS_IDX_SUBST: begin
          subst_r <= reg_wdata[11:0];
        end
        `CODS_IDX_IRQ_EN: begin
          irq_en_r <= reg_wdata[2:0];
        end
        default: begin
          fact_ofs_r <= fact_ofs_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------

  // expiry and run state placed by their field positions
  always @* begin
    status_word = 16'h0000;
    status_word[`CODS_ST_EXPIRED] = expired_r;
    status_word[`CODS_ST_RUN] = run_led_r;
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------

  // read mux, unmapped and write-only indexes read zero
  always @* begin
    rdata_nxt = 16'h0000;
    case (reg_addr)
      `CODS_IDX_FACT_OFS: begin
        rdata_nxt = fact_ofs_r;
      end
      `CODS_IDX_FACT_GAIN: begin
        rdata_nxt = fact_gain_r;
      end
      `CODS_IDX_FEATURE: begin
        rdata_nxt = feature_r;
      end
      `CODS_IDX_CUST_OFS: begin
        rdata_nxt = cust_ofs_r;
      end
      `CODS_IDX_CUST_GAIN: begin
        rdata_nxt = cust_gain_r;
      end
      `CODS_IDX_SUBST: begin
        rdata_nxt = {4'h0, subst_r};
      end
      `CODS_IDX_IRQ_STAT: begin
        rdata_nxt = {13'h0000, irq_stat_r};
      end
      `CODS_IDX_IRQ_EN: begin
        rdata_nxt = {13'h0000, irq_en_r};
      end
      `CODS_IDX_STATUS: begin
        rdata_nxt = status_word;
      end
      `CODS_IDX_DAC_CODE: begin
        rdata_nxt = {4'h0, dac_code_r};
      end
      default: begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 16'h0000;
    end else begin
      reg_rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // format conversion
  // ----------------------------------------------------------------

  // first pipeline step: bring the word into two's complement
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_vld_r <= 1'b0;
      fmt_x_r <= 16'h0000;
    end else begin
      fmt_vld_r <= pd_vld;
      if (pd_vld) begin
        fmt_x_r <= fmt_conv(feature_r[`CODS_FEAT_FMT_MSB:`CODS_FEAT_FMT_LSB], pd_data);
      end
    end
  end

  // ----------------------------------------------------------------
  // scaling stages
  // ----------------------------------------------------------------

  // factory stage works on the converted process value
  cods_line u_fact (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_vld(fmt_vld_r),
    .in_x(fmt_x_r),
    .stage_en(feature_r[`CODS_FEAT_FACT_EN]),
    .ofs(fact_ofs_r),
    .gain(fact_gain_r),
    .out_vld_r(fact_vld),
    .out_y_r(fact_y),
    .out_sat_r(fact_sat)
  );

  // user stage takes the factory result as its input
  cods_line u_cust (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_vld(fact_vld),
    .in_x(fact_y),
    .stage_en(feature_r[`CODS_FEAT_CUST_EN]),
    .ofs(cust_ofs_r),
    .gain(cust_gain_r),
    .out_vld_r(cust_vld),
    .out_y_r(cust_y),
    .out_sat_r(cust_sat)
  );

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------

  // terminal count of the idle counter
  assign wdog_hit = ~pd_vld & ~expired_r & (wdog_cnt_r == (WDOG_CYCLES - 24'h000001));

  // idle counter, restarted by every process word
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_cnt_r <= 24'h000000;
      expired_r <= 1'b1;
      run_led_r <= 1'b0;
    end else if (pd_vld) begin
      wdog_cnt_r <= 24'h000000;
      expired_r <= 1'b0;
      run_led_r <= 1'b1;
    end else if (wdog_hit) begin
      expired_r <= 1'b1;
      run_led_r <= 1'b0;
    end else if (!expired_r) begin
      wdog_cnt_r <= wdog_cnt_r + 24'h000001;
    end
  end

  // ----------------------------------------------------------------
  // converter output
  // ----------------------------------------------------------------

  // substitute write, shown at once while the watchdog holds the output
  assign subst_wr = reg_wr && (reg_addr == `CODS_IDX_SUBST);

  // load scaled data, or the substitute value on expiry
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_code_r <= `CODS_RST_SUBST;
      dac_load_r <= 1'b0;
    end else if (wdog_hit) begin
      dac_code_r <= subst_r;
      dac_load_r <= 1'b1;
    end else if (expired_r && subst_wr) begin
      dac_code_r <= reg_wdata[11:0];
      dac_load_r <= 1'b1;
    end else if (cust_vld && !expired_r) begin
      dac_code_r <= to_code(cust_y);
      dac_load_r <= 1'b1;
    end else begin
      dac_load_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------

  // events of the data path
  assign ev_wdog = wdog_hit;
  assign ev_sat = fact_sat | cust_sat;
  assign ev_resume = pd_vld & expired_r;
  assign wr_clr = reg_wr && (reg_addr == `CODS_IDX_IRQ_CLR);

  // event vector, each event at its own bit position
  always @* begin
    ev_vec = 3'h0;
    ev_vec[`CODS_EV_WDOG] = ev_wdog;
    ev_vec[`CODS_EV_SAT] = ev_sat;
    ev_vec[`CODS_EV_RESUME] = ev_resume;
  end

  // sticky status, a new event wins over a clear
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_clr) begin
      irq_stat_nxt = irq_stat_r & ~reg_wdata[2:0];
    end
    irq_stat_nxt = irq_stat_nxt | ev_vec;
  end

  // status and level interrupt
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_en_r);
    end
  end

endmodule
`default_nettype wire

/* cods_top_tb.sv */
// Purpose: self-checking bench for the scaling data path
// Assumes: coupler model sends words, bench drives the register port
// Notes: watchdog shortened to 50 cycles
`timescale 1ns/1ns
`default_nettype none
module cods_top_tb;
  logic sys_clk, rst_b, go, pd_vld, reg_wr, reg_rd, dac_load_r, run_led_r, irq_r;
  logic [15:0] word, pd_data, reg_wdata, reg_rdata_r;
  logic [7:0] reg_addr;
  logic [11:0] dac_code_r;
  int fails = 0;
  int check_count = 0;
  logic [15:0] wq[$];
  logic [11:0] eq[$];
  cods_coupler cpl_u (.sys_clk(sys_clk), .rst_b(rst_b), .go(go), .word(word), .pd_vld(pd_vld), .pd_data(pd_data));
  cods_top #(.WDOG_CYCLES(24'd50)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .pd_vld(pd_vld), .pd_data(pd_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .dac_code_r(dac_code_r), .dac_load_r(dac_load_r), .run_led_r(run_led_r), .irq_r(irq_r));
  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk("reg_rdata_r", e, reg_rdata_r);
  endtask
  task automatic q(input logic [15:0] w, input logic [11:0] e);
    wq.push_back(w);
    eq.push_back(e);
  endtask
  // queued words back to back, loads collected in order
  task automatic run_words;
    int k;
    k = 0;
    foreach (wq[i]) begin
      @(posedge sys_clk);
      go <= 1'b1;
      word <= wq[i];
    end
    @(posedge sys_clk);
    go <= 1'b0;
    for (int t = 0; t < 20 && k < eq.size(); t++) begin
      @(posedge sys_clk);
      if (dac_load_r === 1'b1) begin
        chk("dac_code_r", eq[k], dac_code_r);
        k++;
      end
    end
    if (k < eq.size()) begin
      $display("unexpected dac_load_r count expected %0d seen %0d", eq.size(), k);
      fails++;
      complete_run;
    end
    wq.delete();
    eq.delete();
  endtask
  task automatic t_regs;
    chk("run_led_r", 16'h0000, run_led_r);
    rd(8'h20, 16'h0000);
    rd(8'h14, 16'h0400);
    rd(8'h22, 16'h0400);
    rd(8'h21, 16'h0000);
    wr(8'h13, 16'h1234);
    rd(8'h13, 16'h1234);
    wr(8'h55, 16'hFFFF);
    rd(8'h55, 16'h0000);
    wr(8'h13, 16'h0000);
  endtask
  task automatic t_direct;
    q(16'h0000, 12'h000);
    q(16'h3FFF, 12'h7FF);
    q(16'h7FFF, 12'hFFF);
    q(16'hFFFF, 12'h000);
    run_words;
    chk("run_led_r", 16'h0001, run_led_r);
  endtask
  task automatic t_scale;
    wr(8'h13, 16'h0100);
    wr(8'h14, 16'h0800);
    wr(8'h21, 16'h0010);
    wr(8'h22, 16'h0200);
    wr(8'h20, 16'h0003);
    q(16'h1000, 12'h212);
    run_words;
    wr(8'h20, 16'h0001);
    q(16'h1000, 12'h102);
    run_words;
    wr(8'h13, 16'h4000);
    wr(8'h14, 16'h0400);
    wr(8'h20, 16'h0002);
    q(16'hFFFF, 12'h7FF);
    run_words;
    wr(8'h20, 16'h0006);
    q(16'hFFFF, 12'h000);
    run_words;
    wr(8'h14, 16'h0800);
    wr(8'h20, 16'h0002);
    q(16'h7FFF, 12'hFFF);
    run_words;
    rd(8'h30, 16'h0006);
    wr(8'h20, 16'h0000);
  endtask
  task automatic t_wdog;
    wr(8'h31, 16'h0007);
    wr(8'h23, 16'h0ABC);
    wr(8'h32, 16'h0001);
    for (int t = 0; t < 200 && run_led_r !== 1'b0; t++) @(posedge sys_clk);
    if (run_led_r !== 1'b0) begin
      $display("unexpected run_led_r expected 0 seen %b", run_led_r);
      fails++;
      complete_run;
    end
    repeat (3) @(posedge sys_clk);
    chk("dac_code_r", 16'h0ABC, dac_code_r);
    chk("irq_r", 16'h0001, irq_r);
    rd(8'h30, 16'h0001);
    wr(8'h31, 16'h0001);
    repeat (3) @(posedge sys_clk);
    chk("irq_r", 16'h0000, irq_r);
    rd(8'h33, 16'h0001);
    wr(8'h23, 16'h0123);
    repeat (2) @(posedge sys_clk);
    chk("dac_code_r", 16'h0123, dac_code_r);
    rd(8'h34, 16'h0123);
    q(16'h7FFF, 12'hFFF);
    run_words;
    chk("run_led_r", 16'h0001, run_led_r);
    rd(8'h30, 16'h0004);
    rd(8'h33, 16'h0002);
  endtask
  // reset, scenarios, verdict
  initial begin
    rst_b = 1'b0;
    go = 1'b0;
    word = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs;
    t_direct;
    t_scale;
    t_wdog;
    complete_run;
  end
endmodule
`default_nettype wire
